// ===== core/ubd_consts.svh
`ifndef UBD_CONSTS_SVH
`define UBD_CONSTS_SVH
// Register offsets within a bank
`define UBD_OFF_DIV_LOW     3'h0
`define UBD_OFF_DIV_HIGH    3'h1
`define UBD_OFF_EXT_ONE     3'h2
`define UBD_OFF_EXT_TWO     3'h4
// Bank numbers
`define UBD_BANK_LEGACY     3'h1
`define UBD_BANK_EXT        3'h2
// Extended control one fields
`define UBD_X1_EXT          0
`define UBD_X1_FAIR         1
`define UBD_X1_THR          2
`define UBD_X1_SWAP         3
`define UBD_X1_LOOP         4
`define UBD_X1_ETD          5
`define UBD_X1_BAUD_TEST_ROUTE        7
`define UBD_X1_RESET        8'h00
// Extended control two fields
`define UBD_X2_LOCK         7
`define UBD_X2_RESET        8'h00
// Fallback clear masks (1 = bit kept)
`define UBD_KEEP_MCR_EXT    8'h03
`define UBD_KEEP_X1_EXT     8'h5E
`define UBD_KEEP_X1_NEXT    8'h5F
`define UBD_KEEP_X2         8'hC0
`define UBD_KEEP_IR1_EXT    8'hF3
// Prescale codes
`define UBD_PRE_13          2'h0
`define UBD_PRE_1625        2'h1
`define UBD_PRE_1           2'h3
// DMA thresholds
`define UBD_TH_RX0          6'h04
`define UBD_TH_TX16_0       6'h0D
`define UBD_TH_TX32_0       6'h1D
`define UBD_TH_RX1          6'h0A
`define UBD_TH_TX16_1       6'h07
`define UBD_TH_TX32_1       6'h17
// Timing
`define UBD_CLK_MHZ         25
`define UBD_FAIR_NS         10500
`define UBD_FAIR_CYC        ((`UBD_FAIR_NS * `UBD_CLK_MHZ) / 1000)
`endif

// ===== core/ubd_pkg.sv
package ubd_pkg;
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ubd_bus_t;

   typedef struct packed {
      logic dtr;
      logic rts;
      logic out1;
      logic out2;
   } ubd_modem_t;

   typedef struct packed {
      logic [15:0] divisor;
      logic [15:0] baud_cnt;
      logic [3:0]  bit_cnt;
      logic [5:0]  pre_cnt;
      logic [7:0]  modem_control;
      logic [7:0]  ext_one;
      logic [7:0]  ext_two;
      logic [7:0]  ir_one;
      logic [7:0]  scratch_low;
      logic [7:0]  scratch_high;
      logic [7:0]  rdata;
      logic [8:0]  fair_cnt;
      logic        fair_block;
      logic        baud_x16;
      logic        bit_tick;
      logic        fallback;
      logic        tx_ser;
      logic        ir_tx;
      logic        dtr_pin;
      logic        rts_pin;
      logic        rx_ser;
      logic        ir_rx;
      logic [3:0]  msts;
      logic        ms_irq_ok;
      logic        txdrq_a;
      logic        rxdrq_a;
      logic        txdack;
      logic        rxdack;
      logic        txdrq_b;
      logic        rxdrq_b;
   } ubd_state_t;
endpackage

// ===== core/ubd_core.sv
// Notes on behaviour
// (RULE1) Prescale 24 MHz by 13, 1.625 or 1
// (RULE2) Divisor gives x16 clock, then divide 16
// (RULE3) Software programs nonzero divisor at init
// (RULE4) Divisor byte write reloads baud counter
// (RULE5) Divisor reset value is left undefined; the code resets it to 0001
// (RULE6) Legacy divisor access forces fallback mode
// (RULE7) Locked non-extended legacy access has no effect
// (RULE8) Extended fallback clears listed control bits
// (RULE9) Non-extended fallback clears fewer bits
// (RULE10) Bank 2 divisor never changes mode
// (RULE11) Bank 2 high write changes rate immediately
// (RULE12) Control one resets zero; bit0 extended
// (RULE13) Fairness: timeout or full/empty drop
// (RULE14) DMA requests follow FIFO thresholds
// (RULE15) Threshold select picks documented levels
// (RULE16) Swap bit exchanges DMA routing
// (RULE17) Loopback ties transmitter to receiver
// (RULE18) Extended loopback drives status from controls
// (RULE19) Loopback idles serial outputs unless enabled
// (RULE20) Loopback disconnects external inputs
// (RULE21) Infrared loopback gates modem status interrupts
// (RULE22) Baud test routes clock to DTR pin
// (RULE23) Lock bit redirects legacy ports to scratch
// (RULE24) Prescale code 00/01/11 selects factor
`include "ubd_consts.svh"

module ubd_core
   import ubd_pkg::*;
#(
   parameter int FAIR_CYCLES = `UBD_FAIR_CYC
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   // Prescaler source enable, one pulse per 24 MHz tick
   input  wire logic       ref_tick_i,
   // Register port
   input  wire logic [2:0] bank_i,
   input  wire ubd_bus_t   bus_i,
   output logic [7:0]      rdata_o,
   // Other control registers of the port
   input  wire logic [7:0] mcr_i,
   input  wire logic       mcr_wr_i,
   input  wire logic [7:0] ir_one_i,
   input  wire logic       ir_one_wr_i,
   input  wire logic       ir_mode_i,
   input  wire logic       ir_mssel_i,
   output logic [7:0]      mcr_o,
   output logic [7:0]      ext_one_o,
   output logic [7:0]      ext_two_o,
   output logic [7:0]      ir_one_o,
   output logic            fallback_o,
   // Baud generation
   output logic            baud_x16_clock_o,
   output logic            bit_tick_o,
   // Serial side, pins
   input  wire logic       rx_pin_i,
   input  wire logic       ir_rx_pin_i,
   input  wire logic [3:0] msts_pin_i,
   input  wire logic       tx_data_i,
   input  wire logic       ir_tx_data_i,
   output logic            tx_pin_o,
   output logic            ir_tx_pin_o,
   output logic            dtr_pin_o,
   output logic            rts_pin_o,
   // Receiver and modem status to internal logic
   output logic            rx_data_o,
   output logic            ir_rx_data_o,
   output logic [3:0]      msts_o,
   output logic            ms_irq_ok_o,
   // DMA
   input  wire logic [5:0] tx_level_i,
   input  wire logic [5:0] rx_level_i,
   input  wire logic       tx_fifo32_i,
   input  wire logic       rx_timeout_i,
   input  wire logic       dack_a_i,
   input  wire logic       dack_b_i,
   output logic            drq_a_o,
   output logic            drq_b_o,
   output logic            tx_dack_o,
   output logic            rx_dack_o
);

   ////////////////////////////////////////////////////////////////////////////
   ubd_state_t state;
   ubd_state_t next_state;
   logic       rx_meta;
   logic       irrx_meta;
   logic [3:0] ms_meta;
   logic       rx_sync;
   logic       irrx_sync;
   logic [3:0] ms_sync;

   // Two-stage synchronisers for pin inputs
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rx_meta   <= 1'b1;
         irrx_meta <= 1'b0;
         ms_meta   <= 4'h0;
         rx_sync   <= 1'b1;
         irrx_sync <= 1'b0;
         ms_sync   <= 4'h0;
      end else begin
         rx_meta   <= rx_pin_i;
         irrx_meta <= ir_rx_pin_i;
         ms_meta   <= msts_pin_i;
         rx_sync   <= rx_meta;
         irrx_sync <= irrx_meta;
         ms_sync   <= ms_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic       ext_mode;
   logic       locked;
   logic       loop_on;
   logic       legacy_hit;
   logic       alt_hit;
   logic       div_wr;
   logic       pre_tick;
   logic       tx_req;
   logic       rx_req;
   logic       tx_stop;
   logic       rx_stop;
   logic [5:0] tx_th;
   logic [5:0] rx_th;
   logic [5:0] pre_lim;
   logic [5:0] pre_inc;
   logic [15:0] new_div;

   always_comb begin
      next_state = state;
      ext_mode   = state.ext_one[`UBD_X1_EXT];
      locked     = state.ext_two[`UBD_X2_LOCK];
      // (RULE17) Loopback storage shared
      loop_on    = ext_mode ? state.ext_one[`UBD_X1_LOOP] : state.modem_control[4];
      legacy_hit = (bank_i == `UBD_BANK_LEGACY) && (bus_i.wr || bus_i.rd)
                   && (bus_i.addr == `UBD_OFF_DIV_LOW || bus_i.addr == `UBD_OFF_DIV_HIGH);
      alt_hit    = (bank_i == `UBD_BANK_EXT) && (bus_i.wr || bus_i.rd)
                   && (bus_i.addr == `UBD_OFF_DIV_LOW || bus_i.addr == `UBD_OFF_DIV_HIGH);
      next_state.fallback = 1'b0;
      next_state.rdata    = 8'h00;
      new_div  = state.divisor;
      div_wr   = 1'b0;

      if (mcr_wr_i) begin
         next_state.modem_control = mcr_i;
      end
      if (ir_one_wr_i) begin
         next_state.ir_one = ir_one_i;
      end

      // Register reads
      if (bus_i.rd) begin
         if (bank_i == `UBD_BANK_EXT) begin
            case (bus_i.addr)
               `UBD_OFF_DIV_LOW:  next_state.rdata = state.divisor[7:0];
               `UBD_OFF_DIV_HIGH: next_state.rdata = state.divisor[15:8];
               `UBD_OFF_EXT_ONE:  next_state.rdata = state.ext_one;
               `UBD_OFF_EXT_TWO:  next_state.rdata = state.ext_two;
               default:           next_state.rdata = 8'h00;
            endcase
         end else if (legacy_hit) begin
            // (RULE23) Scratch overlay when locked
            if (!ext_mode && locked) begin
               next_state.rdata = (bus_i.addr == `UBD_OFF_DIV_LOW) ?
                                  state.scratch_low : state.scratch_high;
            end else begin
               next_state.rdata = (bus_i.addr == `UBD_OFF_DIV_LOW) ?
                                  state.divisor[7:0] : state.divisor[15:8];
            end
         end
      end

      // Register writes
      if (bus_i.wr) begin
         if (bank_i == `UBD_BANK_EXT) begin
            case (bus_i.addr)
               // (RULE10) Alternate divisor port
               `UBD_OFF_DIV_LOW: begin
                  new_div[7:0] = bus_i.wdata;
                  div_wr       = 1'b1;
               end
               // (RULE11) High byte takes effect now
               `UBD_OFF_DIV_HIGH: begin
                  new_div[15:8] = bus_i.wdata;
                  div_wr        = 1'b1;
               end
               // (RULE12) Extended select and controls
               `UBD_OFF_EXT_ONE: next_state.ext_one = bus_i.wdata;
               `UBD_OFF_EXT_TWO: next_state.ext_two = bus_i.wdata & 8'hBF;
               default: ;
            endcase
         end else if (legacy_hit) begin
            // (RULE7) Locked legacy write hits scratch only
            if (!ext_mode && locked) begin
               if (bus_i.addr == `UBD_OFF_DIV_LOW) begin
                  next_state.scratch_low = bus_i.wdata;
               end else begin
                  next_state.scratch_high = bus_i.wdata;
               end
            end else if (bus_i.addr == `UBD_OFF_DIV_LOW) begin
               new_div[7:0] = bus_i.wdata;
               div_wr       = 1'b1;
            end else begin
               new_div[15:8] = bus_i.wdata;
               div_wr        = 1'b1;
            end
         end
      end
      if (loop_on && !ext_mode) begin
         next_state.ext_one[`UBD_X1_LOOP] = next_state.modem_control[4];
      end

      // (RULE6) Legacy access falls back
      if (legacy_hit && (ext_mode || !locked)) begin
         next_state.fallback = 1'b1;
         if (ext_mode) begin
            // (RULE8) Extended fallback clears
            next_state.modem_control     = next_state.modem_control & `UBD_KEEP_MCR_EXT;
            next_state.ext_one = next_state.ext_one & `UBD_KEEP_X1_EXT;
            next_state.ir_one  = next_state.ir_one & `UBD_KEEP_IR1_EXT;
         end else begin
            // (RULE9) Non-extended fallback clears
            next_state.ext_one = next_state.ext_one & `UBD_KEEP_X1_NEXT;
         end
         next_state.ext_two = next_state.ext_two & `UBD_KEEP_X2;
      end

      // (RULE4) Reload counter on divisor write
      next_state.divisor = new_div;

      // (RULE24) Prescale factor decode
      case (state.ext_two[5:4])
         `UBD_PRE_13:   pre_lim = 6'h0D;
         `UBD_PRE_1625: pre_lim = 6'h0D;
         default:       pre_lim = 6'h01;
      endcase
      // (RULE1) 1.625 is thirteen eighths: add 8, wrap at 13
      pre_inc  = (state.ext_two[5:4] == `UBD_PRE_1625) ? 6'h08 : 6'h01;
      pre_tick = 1'b0;
      if (ref_tick_i) begin
         if (state.pre_cnt + pre_inc >= pre_lim) begin
            next_state.pre_cnt = 6'((state.pre_cnt + pre_inc) - pre_lim);
            pre_tick           = 1'b1;
         end else begin
            next_state.pre_cnt = state.pre_cnt + pre_inc;
         end
      end
      // (RULE2) Divisor then divide by 16
      next_state.baud_x16 = 1'b0;
      next_state.bit_tick = 1'b0;
      if (div_wr) begin
         next_state.baud_cnt = new_div;
      end else if (pre_tick) begin
         if (state.baud_cnt <= 16'h0001) begin
            next_state.baud_cnt = state.divisor;
            next_state.baud_x16 = 1'b1;
            next_state.bit_cnt  = state.bit_cnt + 4'h1;
            next_state.bit_tick = (state.bit_cnt == 4'hF);
         end else begin
            next_state.baud_cnt = state.baud_cnt - 16'h0001;
         end
      end

      // (RULE19) Serial outputs in loopback
      if (loop_on && !state.ext_one[`UBD_X1_ETD]) begin
         next_state.tx_ser = 1'b1;
         next_state.ir_tx  = 1'b0;
      end else begin
         next_state.tx_ser = tx_data_i;
         next_state.ir_tx  = ir_tx_data_i;
      end
      // (RULE22) Baud test on DTR
      next_state.dtr_pin = state.ext_one[`UBD_X1_BAUD_TEST_ROUTE] ? state.baud_x16
                           : !(state.modem_control[0] && !loop_on);
      next_state.rts_pin = !(state.modem_control[1] && !loop_on);

      // (RULE17) Receiver fed from transmitter
      // (RULE20) External inputs cut off
      if (loop_on) begin
         next_state.rx_ser = tx_data_i;
         next_state.ir_rx  = ir_tx_data_i;
         // (RULE18) Extended status mapping: cts,dsr,ri,dcd
         if (ext_mode) begin
            next_state.msts = {state.modem_control[1], state.modem_control[0], state.modem_control[0], state.modem_control[1]};
         end else begin
            next_state.msts = {state.modem_control[1], state.modem_control[0], state.modem_control[2], state.modem_control[3]};
         end
      end else begin
         next_state.rx_ser = rx_sync;
         next_state.ir_rx  = irrx_sync;
         next_state.msts   = ~ms_sync;
      end
      // (RULE21) IR loopback status interrupt gate
      next_state.ms_irq_ok = !(loop_on && ir_mode_i && ir_mssel_i);

      // (RULE15) Threshold levels
      if (state.ext_one[`UBD_X1_THR]) begin
         rx_th = `UBD_TH_RX1;
         tx_th = tx_fifo32_i ? `UBD_TH_TX32_1 : `UBD_TH_TX16_1;
      end else begin
         rx_th = `UBD_TH_RX0;
         tx_th = tx_fifo32_i ? `UBD_TH_TX32_0 : `UBD_TH_TX16_0;
      end
      // (RULE14) Threshold requests
      tx_req = tx_level_i < tx_th;
      rx_req = (rx_level_i >= rx_th) || rx_timeout_i;
      // (RULE13) Fairness timing or full/empty
      tx_stop = tx_level_i >= (tx_fifo32_i ? 6'd32 : 6'd16);
      rx_stop = rx_level_i == 6'd0;
      if (!state.ext_one[`UBD_X1_FAIR]) begin
         tx_stop = state.fair_block;
         rx_stop = state.fair_block;
         if ((state.txdrq_a || state.rxdrq_a) && !state.fair_block) begin
            if (32'(state.fair_cnt) + 1 >= FAIR_CYCLES) begin
               next_state.fair_block = 1'b1;
            end
            next_state.fair_cnt = state.fair_cnt + 9'd1;
         end else begin
            next_state.fair_cnt   = 9'd0;
            next_state.fair_block = 1'b0;
         end
      end else begin
         next_state.fair_cnt   = 9'd0;
         next_state.fair_block = 1'b0;
      end
      next_state.txdrq_a = tx_req && !tx_stop;
      next_state.rxdrq_a = rx_req && !rx_stop;
      // (RULE16) Swap routing
      if (state.ext_one[`UBD_X1_SWAP]) begin
         next_state.txdrq_b = state.rxdrq_a;
         next_state.rxdrq_b = state.txdrq_a;
         next_state.txdack  = dack_b_i;
         next_state.rxdack  = dack_a_i;
      end else begin
         next_state.txdrq_b = state.txdrq_a;
         next_state.rxdrq_b = state.rxdrq_a;
         next_state.txdack  = dack_a_i;
         next_state.rxdack  = dack_b_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // (RULE5) Divisor reset value fixed at 0001
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state         <= '0;
         state.divisor <= 16'h0001;
         state.tx_ser  <= 1'b1;
         state.dtr_pin <= 1'b1;
         state.rts_pin <= 1'b1;
         state.rx_ser  <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign rdata_o          = state.rdata;
   assign mcr_o            = state.modem_control;
   assign ext_one_o        = state.ext_one;
   assign ext_two_o        = state.ext_two;
   assign ir_one_o         = state.ir_one;
   assign fallback_o       = state.fallback;
   assign baud_x16_clock_o = state.baud_x16;
   assign bit_tick_o       = state.bit_tick;
   assign tx_pin_o         = state.tx_ser;
   assign ir_tx_pin_o      = state.ir_tx;
   assign dtr_pin_o        = state.dtr_pin;
   assign rts_pin_o        = state.rts_pin;
   assign rx_data_o        = state.rx_ser;
   assign ir_rx_data_o     = state.ir_rx;
   assign msts_o           = state.msts;
   assign ms_irq_ok_o      = state.ms_irq_ok;
   assign drq_a_o          = state.txdrq_b;
   assign drq_b_o          = state.rxdrq_b;
   assign tx_dack_o        = state.txdack;
   assign rx_dack_o        = state.rxdack;

endmodule // ubd_core

// ===== dv/ubd_core_checker.sv
module ubd_core_checker
   import ubd_pkg::*;
(
   // Clock and reset
   input wire logic       clk_i,
   input wire logic       reset_i,
   // Register side
   input wire logic [2:0] bank_i,
   input wire ubd_bus_t   bus_i,
   input wire logic [7:0] mcr_o,
   input wire logic [7:0] ext_one_o,
   input wire logic [7:0] ext_two_o,
   input wire logic [7:0] ir_one_o,
   input wire logic       fallback_o,
   // Serial side
   input wire logic       tx_data_i,
   input wire logic       tx_pin_o,
   input wire logic       rx_data_o,
   input wire logic [3:0] msts_o,
   input wire logic       bit_tick_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic leg;
   logic loop;
   assign leg  = bank_i == 3'h1 && bus_i.addr < 3'h2 && (bus_i.wr || bus_i.rd);
   assign loop = ext_one_o[0] && ext_one_o[4];
   ////////////////////////////////////////
   chk_reset_zero: assert property ($past(reset_i) |-> ext_one_o == 8'h00)
      else $error("control one not zero after reset");
   chk_leg_fallback: assert property (leg && ext_one_o[0] |=> fallback_o)
      else $error("no fallback after legacy access");
   chk_lock_quiet: assert property (leg && !ext_one_o[0] && ext_two_o[7] |=> !fallback_o)
      else $error("locked legacy access fell back");
   chk_alt_quiet: assert property (bank_i == 3'h2 && (bus_i.wr || bus_i.rd) |=> !fallback_o)
      else $error("alternate access fell back");
   chk_fall_clear: assert property (fallback_o |-> !(|(ext_one_o & 8'hA0)) && !(|ext_two_o[5:0]))
      else $error("fallback left control bits set");
   chk_fall_ext: assert property (fallback_o && $past(ext_one_o[0])
      |-> !ext_one_o[0] && !(|mcr_o[7:2]) && !(|ir_one_o[3:2]))
      else $error("extended fallback left bits set");
   chk_fall_keep: assert property (fallback_o && !$past(ext_one_o[0])
      |-> mcr_o == $past(mcr_o) && ir_one_o == $past(ir_one_o))
      else $error("plain fallback touched modem or infrared");
   chk_loop_idle: assert property (loop && $past(loop) && !ext_one_o[5] && !$past(ext_one_o[5])
      |-> tx_pin_o)
      else $error("serial out not idle in loopback");
   chk_loop_echo: assert property (loop && $past(loop) && $stable(tx_data_i)
      |-> rx_data_o == tx_data_i)
      else $error("loopback data not echoed");
   chk_loop_msts: assert property (loop && $past(loop) && $stable(mcr_o[1:0])
      |-> msts_o == {mcr_o[1], mcr_o[0], mcr_o[0], mcr_o[1]})
      else $error("loopback status not from controls");
   cov_fallback: cover property (fallback_o);
   cov_bit_tick: cover property (bit_tick_o);
   cov_loop: cover property (loop && rx_data_o);
endmodule // ubd_core_checker

bind ubd_core ubd_core_checker chk (
   .clk_i(clk_i), .reset_i(reset_i), .bank_i(bank_i), .bus_i(bus_i), .mcr_o(mcr_o),
   .ext_one_o(ext_one_o), .ext_two_o(ext_two_o), .ir_one_o(ir_one_o),
   .fallback_o(fallback_o), .tx_data_i(tx_data_i), .tx_pin_o(tx_pin_o),
   .rx_data_o(rx_data_o), .msts_o(msts_o), .bit_tick_o(bit_tick_o)
);

// ===== dv/ubd_far_model.sv
module ubd_far_model (
   // Clock
   input  wire logic       clk_i,
   // From the block
   input  wire logic       tx_pin_i,
   input  wire logic       ir_tx_pin_i,
   input  wire logic       dtr_pin_i,
   input  wire logic       rts_pin_i,
   input  wire logic       drq_a_i,
   input  wire logic       drq_b_i,
   input  wire logic       slow_i,
   // To the block
   output logic            rx_pin_o,
   output logic            ir_rx_pin_o,
   output logic [3:0]      msts_pin_o,
   output logic            dack_a_o = 1'b0,
   output logic            dack_b_o = 1'b0
);
   logic [3:0] wait_cnt = 4'h0;
   // Null modem: line echoes, controls return as status
   assign rx_pin_o    = tx_pin_i;
   assign ir_rx_pin_o = ~ir_tx_pin_i;
   assign msts_pin_o  = {rts_pin_i, dtr_pin_i, dtr_pin_i, rts_pin_i};
   // Acknowledge promptly, or after a stall when slow
   always_ff @(posedge clk_i) begin
      if (!(drq_a_i || drq_b_i)) begin
         wait_cnt <= 4'h0;
      end else if (wait_cnt != 4'hF) begin
         wait_cnt <= wait_cnt + 4'h1;
      end
      dack_a_o <= drq_a_i && (!slow_i || wait_cnt > 4'h6);
      dack_b_o <= drq_b_i && (!slow_i || wait_cnt > 4'h6);
   end
endmodule // ubd_far_model

// ===== dv/ubd_core_tb.sv
module ubd_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ubd_pkg::*;
   localparam int FAIR = 8;
   logic       clk_i = 1'b0;
   logic       reset_i = 1'b1;
   logic [2:0] bank = 3'h2;
   ubd_bus_t   bus = '0;
   logic [7:0] mcr_in = 8'h00;
   logic       mcr_wr = 1'b0;
   logic       ir_wr = 1'b0;
   logic       ir_mode = 1'b0;
   logic       ir_mssel = 1'b0;
   logic       tx_d = 1'b1;
   logic       irtx_d = 1'b0;
   logic [5:0] tx_lvl = 6'h10;
   logic [5:0] rx_lvl = 6'h00;
   logic       f32 = 1'b0;
   logic       rto = 1'b0;
   logic       slow = 1'b0;
   logic [7:0] rdata, modem_control, x1, x2, ir1;
   logic       fb, b16, btk, txp, irtxp, dtrp, rtsp, rxd, irrxd, msok;
   logic       drqa, drqb, dacka, dackb, rxp, irrxp;
   logic [3:0] msts, mspin;
   logic [17:0] tbl [10];
   int         failures = 0;
   int         tests_run = 0;
   int         cyc = 0;

   ubd_core #(.FAIR_CYCLES(FAIR)) uut (
      .clk_i(clk_i), .reset_i(reset_i), .ref_tick_i(1'b1), .bank_i(bank), .bus_i(bus),
      .rdata_o(rdata), .mcr_i(mcr_in), .mcr_wr_i(mcr_wr), .ir_one_i(mcr_in),
      .ir_one_wr_i(ir_wr), .ir_mode_i(ir_mode), .ir_mssel_i(ir_mssel), .mcr_o(modem_control),
      .ext_one_o(x1), .ext_two_o(x2), .ir_one_o(ir1), .fallback_o(fb),
      .baud_x16_clock_o(b16), .bit_tick_o(btk), .rx_pin_i(rxp), .ir_rx_pin_i(irrxp),
      .msts_pin_i(mspin), .tx_data_i(tx_d), .ir_tx_data_i(irtx_d), .tx_pin_o(txp),
      .ir_tx_pin_o(irtxp), .dtr_pin_o(dtrp), .rts_pin_o(rtsp), .rx_data_o(rxd),
      .ir_rx_data_o(irrxd), .msts_o(msts), .ms_irq_ok_o(msok), .tx_level_i(tx_lvl),
      .rx_level_i(rx_lvl), .tx_fifo32_i(f32), .rx_timeout_i(rto), .dack_a_i(dacka),
      .dack_b_i(dackb), .drq_a_o(drqa), .drq_b_o(drqb), .tx_dack_o(), .rx_dack_o()
   );
   ubd_far_model far (
      .clk_i(clk_i), .tx_pin_i(txp), .ir_tx_pin_i(irtxp), .dtr_pin_i(dtrp),
      .rts_pin_i(rtsp), .drq_a_i(drqa), .drq_b_i(drqb), .slow_i(slow), .rx_pin_o(rxp),
      .ir_rx_pin_o(irrxp), .msts_pin_o(mspin), .dack_a_o(dacka), .dack_b_o(dackb)
   );
   ////////////////////////////////////////
   task automatic give_verdict();
      $display("comparisons %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] b, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bank <= b;
      bus <= {a, d, 1'b1, 1'b0};
      @(posedge clk_i);
      bus.wr <= 1'b0;
   endtask
   task automatic rc(input logic [2:0] b, input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      bank <= b;
      bus <= {a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_i);
      bus.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic ld(input logic ir, input logic [7:0] d);
      @(posedge clk_i);
      mcr_in <= d;
      mcr_wr <= !ir;
      ir_wr <= ir;
      @(posedge clk_i);
      mcr_wr <= 1'b0;
      ir_wr <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Cycles spanned by eight x16 pulses, after the rate has settled
   task automatic span(output int n);
      int k;
      n = 0;
      k = 0;
      repeat (2) @(posedge clk_i iff b16);
      while (k < 8) begin
         @(posedge clk_i);
         n++;
         k += b16;
      end
   endtask
   ////////////////////////////////////////
   initial forever begin
      #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         give_verdict();
      end
   end
   initial begin
      int n;
      // {swap, thr, f32, timeout, tx level, rx level, drq a, drq b}
      tbl = '{{4'h0, 6'h0C, 6'h03, 2'h2}, {4'h0, 6'h0D, 6'h04, 2'h1},
              {4'h2, 6'h1C, 6'h00, 2'h2}, {4'h2, 6'h1D, 6'h00, 2'h0},
              {4'h4, 6'h06, 6'h09, 2'h2}, {4'h4, 6'h07, 6'h0A, 2'h1},
              {4'h6, 6'h16, 6'h00, 2'h2}, {4'h6, 6'h17, 6'h00, 2'h0},
              {4'h1, 6'h14, 6'h02, 2'h1}, {4'h8, 6'h00, 6'h00, 2'h1}};
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      rc(3'h2, 3'h2, 8'h00);
      rc(3'h2, 3'h4, 8'h00);
      rc(3'h2, 3'h5, 8'h00);
      // Divisor of five; never zero between byte writes
      wr(3'h2, 3'h0, 8'h05);
      wr(3'h2, 3'h1, 8'h00);
      wr(3'h2, 3'h4, 8'h10);
      span(n);
      chk(n, 65);
      wr(3'h2, 3'h4, 8'h00);
      span(n);
      chk(n, 520);
      wr(3'h2, 3'h4, 8'h30);
      span(n);
      chk(n, 40);
      @(posedge clk_i iff btk);
      n = 0;
      do begin
         @(posedge clk_i);
         n += b16;
      end while (!btk);
      chk(n, 16);
      // Reload: long divisor, then a short one takes effect at once
      wr(3'h2, 3'h1, 8'h01);
      wr(3'h2, 3'h0, 8'h00);
      settle(20);
      wr(3'h2, 3'h0, 8'h03);
      wr(3'h2, 3'h1, 8'h00);
      n = 0;
      while (!b16 && n < 12) begin
         @(posedge clk_i);
         n++;
      end
      chk(n <= 4, 1'b1);
      // Fallback from extended mode
      ld(1'b0, 8'hEF);
      ld(1'b1, 8'hFF);
      wr(3'h2, 3'h4, 8'h3F);
      wr(3'h2, 3'h2, 8'hE1);
      rc(3'h1, 3'h1, 8'h00);
      settle(1);
      chk({x1 & 8'hBF, x2}, 16'h0000);
      chk({modem_control, ir1}, 16'h03F3);
      // Fallback from plain mode, unlocked
      ld(1'b0, 8'hEF);
      wr(3'h2, 3'h4, 8'h3F);
      wr(3'h2, 3'h2, 8'hE4);
      wr(3'h1, 3'h0, 8'h05);
      settle(1);
      chk({x1 & 8'hBF, x2}, 16'h0400);
      chk({modem_control, ir1}, 16'hEFF3);
      // Locked: legacy ports reach scratch only
      wr(3'h2, 3'h4, 8'h80);
      wr(3'h1, 3'h0, 8'h5A);
      rc(3'h1, 3'h0, 8'h5A);
      rc(3'h2, 3'h0, 8'h05);
      chk(x2, 8'h80);
      wr(3'h2, 3'h4, 8'h30);
      wr(3'h2, 3'h2, 8'h01);
      wr(3'h2, 3'h1, 8'h00);
      rc(3'h2, 3'h0, 8'h05);
      chk(x1 & 8'hBF, 8'h01);
      // Extended loopback, transmitter held idle until ETD is set
      ld(1'b0, 8'h01);
      wr(3'h2, 3'h2, 8'h11);
      tx_d <= 1'b0;
      irtx_d <= 1'b1;
      ir_mode <= 1'b1;
      ir_mssel <= 1'b1;
      settle(4);
      chk({txp, irtxp, rxd}, 3'h4);
      chk(msts, 4'h6);
      chk(msok, 1'b0);
      @(posedge clk_i);
      ir_mssel <= 1'b0;
      tx_d <= 1'b1;
      settle(4);
      chk({rxd, msok}, 2'h3);
      wr(3'h2, 3'h2, 8'h31);
      tx_d <= 1'b0;
      settle(4);
      chk(txp, 1'b0);
      // Baud clock on the terminal-ready pin
      wr(3'h2, 3'h2, 8'h81);
      settle(2);
      n = 0;
      repeat (100) begin
         @(posedge clk_i);
         n += dtrp;
      end
      chk(n >= 10 && n <= 90, 1'b1);
      // DMA thresholds, timeout and swap, far side stalling
      slow <= 1'b1;
      foreach (tbl[i]) begin
         wr(3'h2, 3'h2, {4'h0, tbl[i][17:16], 2'h3});
         f32 <= tbl[i][15];
         rto <= tbl[i][14];
         tx_lvl <= tbl[i][13:8];
         rx_lvl <= tbl[i][7:2];
         settle(4);
         chk({drqa, drqb}, tbl[i][1:0]);
      end
      @(posedge clk_i);
      slow <= 1'b0;
      rto <= 1'b0;
      wr(3'h2, 3'h2, 8'h01);
      n = 0;
      repeat (40) begin
         @(posedge clk_i);
         n += drqa;
      end
      chk(n > 0 && n < 40, 1'b1);
      give_verdict();
   end
endmodule // ubd_core_tb
